// file: core/psr_pkg.sv
// package for the power sense and reset output block
// assumes a single 40 MHz ref_clk domain and an AXI4-Lite register port
package psr_pkg;
  // =====================================================================
  // timing
  localparam int unsigned CLK_MHZ = 40; // ref_clk rate
  localparam int unsigned ASSERT_DELAY_NS = 5000; // about 5 us from event to pin low
  localparam int unsigned ASSERT_DELAY_CYC = (ASSERT_DELAY_NS * CLK_MHZ) / 1000;
  localparam int unsigned MIN_PULSE_NS = 2000000; // least low time of a reset pin
  localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PG_MIN_LOW_CYC = 40; // default low qualification count
  localparam int unsigned PG_MIN_HIGH_CYC = 40; // default high qualification count
  localparam int unsigned PARK_TIMEOUT_CYC = 4000; // give up waiting on park done
  // =====================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] INT_STAT_OFS = 8'h0C;
  localparam logic [7:0] INT_MASK_OFS = 8'h10;
  // =====================================================================
  // field positions and reset values
  localparam int unsigned CTRL_GEN_FORCE = 0; // drive general reset low
  localparam int unsigned CTRL_MTR_FORCE = 1; // drive motor reset low
  localparam int unsigned CTRL_MTR_AUTO = 2; // motor follows power loss/internal reset
  localparam int unsigned CTRL_MTR_LAMP_DIS = 3; // lamp strike leaves motor alone
  localparam logic [3:0] CTRL_RESET = 4'h4;
  localparam int unsigned CMD_GEN_REL = 0; // write 1: release general reset
  localparam int unsigned CMD_MTR_REL = 1; // write 1: release motor reset
  localparam int unsigned CMD_SOFT_RST = 2; // write 1: internal reset event
  localparam int unsigned INT_PG_LOSS = 0;
  localparam int unsigned INT_PG_GOOD = 1;
  localparam int unsigned INT_GEN_LOW = 2;
  localparam int unsigned INT_MTR_LOW = 3;
  localparam logic [3:0] INT_MASK_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // power loss sequence states
  typedef enum logic [1:0] {
    PSR_IDLE = 2'b00,
    PSR_PARK = 2'b01,
    PSR_HOLD = 2'b10
  } psr_state_e;
endpackage : psr_pkg

// file: core/psr_qualify.sv
// synchroniser and high/low time qualifier for the power good pin
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module psr_qualify
#(
  parameter int unsigned MIN_LOW = 40,
  parameter int unsigned MIN_HIGH = 40
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pin and qualified level
  input wire logic pin_in,
  output logic level_q,
  output logic fall_pulse,
  output logic rise_pulse
);
  localparam int unsigned CW = $clog2((MIN_LOW > MIN_HIGH ? MIN_LOW : MIN_HIGH) + 1);
  logic sync1_q; // first stage, read only by sync2_q
  logic sync2_q; // second stage, safe to use
  logic [CW-1:0] cnt_q; // cycles the pin has differed from level_q
  logic last; // this cycle completes the qualification time
  // =====================================================================
  // two-flop synchroniser
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end
  // compare against the limit of the direction being qualified
  assign last = sync2_q ? (cnt_q == CW'(MIN_HIGH - 1)) : (cnt_q == CW'(MIN_LOW - 1));
  // =====================================================================
  // qualification counter: any bounce back restarts it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      level_q <= 1'b0; // power good counts as inactive until qualified
    end
    else if (sync2_q == level_q)
    begin
      cnt_q <= '0; // short pulse ignored as glitch
    end
    else if (last)
    begin
      cnt_q <= '0;
      level_q <= sync2_q; // stayed put for the full time
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign fall_pulse = level_q & ~sync2_q & last;
  assign rise_pulse = ~level_q & sync2_q & last;
endmodule : psr_qualify
`default_nettype wire

// file: core/psr_top.sv
// power sense sequencing and the two active-low reset outputs
// assumes power_on_sense and power_good_warning come from an outside monitor,
// lamp strike and park done come from logic on ref_clk
// Contract
// - both resets low while power-on sense low
// - after sense rises, software releases each reset
// - general reset low 5 us after event
// - each reset stays low at least 2 ms
// - software bit forces each reset independently
// - motor reset follows events when enabled
// - software bit keeps lamp strike off motor
// - qualified power loss: park, then controller reset
// - short power-good low pulses are ignored
// - controller held in reset while power-good low (held only in PSR_HOLD, after a qualified loss and the park)
// - power-good active only after stable high time
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module psr_top
#(
  parameter int unsigned MIN_PULSE_CYC = psr_pkg::MIN_PULSE_CYC,
  parameter int unsigned PG_MIN_LOW = psr_pkg::PG_MIN_LOW_CYC,
  parameter int unsigned PG_MIN_HIGH = psr_pkg::PG_MIN_HIGH_CYC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // monitor pins
  input wire logic power_on_sense,
  input wire logic power_good_warning,
  // internal reset sources and park handshake
  input wire logic lamp_strike_rst,
  input wire logic mirror_park_done,
  output logic mirror_park_req,
  output logic ctrl_reset_out,
  // reset pins
  output logic general_reset_out_n,
  output logic motor_reset_out_n,
  // interrupt
  output logic irq,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import psr_pkg::*;
  localparam int unsigned SW = $clog2(MIN_PULSE_CYC + 1);
  localparam int unsigned PW = $clog2(PARK_TIMEOUT_CYC + 1);
  // =====================================================================
  // declarations
  logic pos_s1_q; // sense sync stage 1, read only by pos_s2_q
  logic pos_s2_q; // synchronised power-on sense
  logic pg_q; // qualified power good
  logic pg_fall, pg_rise; // qualified loss and return, one cycle each
  psr_state_e state_q; // power loss sequence
  logic [PW-1:0] park_cnt_q; // park wait timer
  logic [3:0] ctrl_q, int_stat_q, int_mask_q; // control, sticky events, interrupt enables
  logic [2:0] cmd; // write-one command pulses
  logic [1:0] ch_evt, ch_force, ch_low, ch_hold; // per channel: event, force, low, held
  logic [1:0] ch_low_d1_q; // for assertion edge detection
  logic soft_evt; // internal reset from software
  logic aw_full_q, w_full_q; // write address, write data captured
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write, wr_hit; // both halves in with response slot free; address maps
  logic [31:0] rd_mux; // read data before the register
  logic rd_hit; // read address maps to a register
  // =====================================================================
  // power-on sense synchroniser
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pos_s1_q <= 1'b0;
      pos_s2_q <= 1'b0;
    end
    else
    begin
      pos_s1_q <= power_on_sense;
      pos_s2_q <= pos_s1_q;
    end
  end
  // power good deglitch and qualification
  psr_qualify #(
    .MIN_LOW(PG_MIN_LOW),
    .MIN_HIGH(PG_MIN_HIGH)
  ) u_pg_qual (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(power_good_warning),
    .level_q(pg_q),
    .fall_pulse(pg_fall),
    .rise_pulse(pg_rise)
  );
  // =====================================================================
  // power loss sequence: park the mirrors, then reset the controller
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= PSR_IDLE;
      park_cnt_q <= '0;
      mirror_park_req <= 1'b0;
      ctrl_reset_out <= 1'b0;
    end
    else
    begin
      mirror_park_req <= (state_q == PSR_PARK);
      ctrl_reset_out <= (state_q == PSR_HOLD);
      park_cnt_q <= (state_q == PSR_PARK) ? park_cnt_q + 1'b1 : '0;
      // a stuck park must not keep the controller out of reset
      unique case (state_q)
        PSR_IDLE:
          if (pg_fall)
            state_q <= PSR_PARK; // park comes first
        PSR_PARK:
          if (mirror_park_done || park_cnt_q == PW'(PARK_TIMEOUT_CYC - 1))
            state_q <= PSR_HOLD; // then the full reset
        PSR_HOLD:
          if (pg_q)
            state_q <= PSR_IDLE; // held until power good requalifies
      endcase
    end
  end
  // =====================================================================
  // event routing to the two reset channels
  assign soft_evt = cmd[CMD_SOFT_RST];
  assign ch_evt[0] = pg_fall | soft_evt | lamp_strike_rst;
  // motor: only when enabled, lamp strike maskable
  assign ch_evt[1] = ctrl_q[CTRL_MTR_AUTO]
    & (pg_fall | soft_evt | (lamp_strike_rst & ~ctrl_q[CTRL_MTR_LAMP_DIS]));
  assign ch_force[0] = ctrl_q[CTRL_GEN_FORCE];
  assign ch_force[1] = ctrl_q[CTRL_MTR_FORCE];
  // =====================================================================
  // per-channel reset generation
  generate
    for (genvar gi = 0; gi < 2; gi++)
    begin : g_ch
      logic hold_q; // waiting for software release
      logic dly_act_q; // delay to assertion running
      logic [7:0] dly_cnt_q;
      logic fire, src; // delay expired this cycle; something wants the pin low now
      logic [SW-1:0] str_cnt_q; // stretch to the least low time
      logic out_n_q; // pin value
      // held from sense low until software release; sense low wins
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          hold_q <= 1'b1;
        else if (!pos_s2_q)
          hold_q <= 1'b1;
        else if (cmd[gi])
          hold_q <= 1'b0; // released only by software
      end
      // roughly 5 us from event to assertion; events inside merge
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          dly_act_q <= 1'b0;
          dly_cnt_q <= '0;
        end
        else
        begin
          dly_act_q <= dly_act_q ? ~fire : ch_evt[gi];
          dly_cnt_q <= dly_act_q ? dly_cnt_q + 1'b1 : '0;
        end
      end
      assign fire = dly_act_q && dly_cnt_q == 8'(ASSERT_DELAY_CYC - 1);
      assign src = hold_q | ~pos_s2_q | ch_force[gi] | fire;
      // pulse stretch: every cause keeps the pin low the least time
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          str_cnt_q <= '0;
          out_n_q <= 1'b0;
        end
        else
        begin
          str_cnt_q <= src ? SW'(MIN_PULSE_CYC - 1) : str_cnt_q - SW'(str_cnt_q != '0);
          out_n_q <= ~(src | (str_cnt_q != '0));
        end
      end
      assign ch_low[gi] = ~out_n_q;
      assign ch_hold[gi] = hold_q;
    end
  endgenerate
  assign general_reset_out_n = ~ch_low[0];
  assign motor_reset_out_n = ~ch_low[1];
  // =====================================================================
  // interrupt status: set wins over a same-cycle clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ch_low_d1_q <= 2'h3;
      int_stat_q <= 4'h0;
    end
    else
    begin
      ch_low_d1_q <= ch_low;
      if (do_write && aw_addr_q == INT_STAT_OFS && w_strb_q[0])
        int_stat_q <= (int_stat_q & ~w_data_q[3:0]) | {ch_low & ~ch_low_d1_q, pg_rise, pg_fall};
      else
        int_stat_q <= int_stat_q | {ch_low & ~ch_low_d1_q, pg_rise, pg_fall};
    end
  end
  // level interrupt while any enabled bit is set
  assign irq = |(int_stat_q & int_mask_q);
  // =====================================================================
  // axi4-lite write channel
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_hit = aw_addr_q == CTRL_OFS || aw_addr_q == CMD_OFS
    || aw_addr_q == INT_STAT_OFS || aw_addr_q == INT_MASK_OFS;
  // capture address and data in either order
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      else if (do_write)
        aw_full_q <= 1'b0;
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (do_write)
        w_full_q <= 1'b0;
    end
  end
  // write response, held until the master takes it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
  // command pulses: one cycle, only byte 0 counts
  assign cmd = (do_write && aw_addr_q == CMD_OFS && w_strb_q[0]) ? w_data_q[2:0] : 3'h0;
  // control and mask registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RESET;
      int_mask_q <= INT_MASK_RESET;
    end
    else if (do_write && w_strb_q[0])
    begin
      if (aw_addr_q == CTRL_OFS)
        ctrl_q <= w_data_q[3:0];
      if (aw_addr_q == INT_MASK_OFS)
        int_mask_q <= w_data_q[3:0];
    end
  end
  // =====================================================================
  // axi4-lite read channel
  assign s_axi_arready = ~s_axi_rvalid;
  // read mux; unused bits read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      CTRL_OFS: rd_mux[3:0] = ctrl_q;
      CMD_OFS: rd_mux = 32'h0000_0000; // commands read back as zero
      STATUS_OFS: rd_mux[7:0] = {state_q, ch_hold, ch_low, pg_q, pos_s2_q};
      INT_STAT_OFS: rd_mux[3:0] = int_stat_q;
      INT_MASK_OFS: rd_mux[3:0] = int_mask_q;
      default: rd_hit = 1'b0;
    endcase
  end
  // read data registered, held until taken
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule : psr_top
`default_nettype wire

// file: verif/psr_properties.sv
// checker for psr_top, attached by bind at the foot of this file
// assumes one ref_clk domain and rst active high
`timescale 1ns/100ps
`default_nettype none
module psr_properties
#(
  parameter int unsigned MIN_PULSE_CYC = 50,
  parameter int unsigned PG_MIN_LOW = 4,
  parameter int unsigned PG_MIN_HIGH = 4
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // monitor pins and internal sources
  input wire logic power_on_sense,
  input wire logic power_good_warning,
  input wire logic lamp_strike_rst,
  input wire logic mirror_park_req,
  input wire logic ctrl_reset_out,
  // reset pins
  input wire logic general_reset_out_n,
  input wire logic motor_reset_out_n,
  // write response
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  // ==========
  // helper logic
  int unsigned g_lo, m_lo, pg_hi, pg_lo; // run lengths in cycles
  logic seen; // a write was answered since sense was last low
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // the pg low run clears only after a long high, so glitches add up (weaker, never false)
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      g_lo <= 0;
      m_lo <= 0;
      pg_hi <= 0;
      pg_lo <= 0;
      seen <= 1'b0;
    end
    else
    begin
      g_lo <= general_reset_out_n ? 0 : g_lo + 1;
      m_lo <= motor_reset_out_n ? 0 : m_lo + 1;
      pg_hi <= power_good_warning ? pg_hi + 1 : 0;
      pg_lo <= power_good_warning ? (pg_hi > 8 ? 0 : pg_lo) : pg_lo + 1;
      if (!power_on_sense) seen <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready) seen <= 1'b1;
    end
  end
  // ==========
  // properties
  property p_sense_low;
    !power_on_sense [*3] |=> !general_reset_out_n && !motor_reset_out_n;
  endproperty
  a_sense_low: assert property (p_sense_low) else $error("pin high with sense low");
  property p_sw_release;
    $rose(general_reset_out_n) || $rose(motor_reset_out_n) |-> seen;
  endproperty
  a_sw_release: assert property (p_sw_release) else $error("pin rose unreleased");
  property p_gen_pulse;
    $rose(general_reset_out_n) |-> g_lo >= MIN_PULSE_CYC;
  endproperty
  a_gen_pulse: assert property (p_gen_pulse) else $error("general pulse short");
  property p_mtr_pulse;
    $rose(motor_reset_out_n) |-> m_lo >= MIN_PULSE_CYC;
  endproperty
  a_mtr_pulse: assert property (p_mtr_pulse) else $error("motor pulse short");
  property p_evt_delay;
    lamp_strike_rst && general_reset_out_n |-> ##[200:202] !general_reset_out_n;
  endproperty
  a_evt_delay: assert property (p_evt_delay) else $error("event delay wrong");
  property p_park_first;
    $rose(ctrl_reset_out) |-> $past(mirror_park_req) || $past(mirror_park_req, 2);
  endproperty
  a_park_first: assert property (p_park_first) else $error("reset before park");
  property p_hold_low;
    ctrl_reset_out && !power_good_warning |=> ctrl_reset_out;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("hold left while pg low");
  property p_glitch;
    power_good_warning [*8] ##1 !power_good_warning && !mirror_park_req
      ##1 power_good_warning |=> !mirror_park_req [*6];
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch started park");
  property p_qual_high;
    $fell(ctrl_reset_out) |-> pg_hi >= PG_MIN_HIGH;
  endproperty
  a_qual_high: assert property (p_qual_high) else $error("pg good too soon");
  property p_qual_low;
    $rose(mirror_park_req) |-> pg_lo >= PG_MIN_LOW;
  endproperty
  a_qual_low: assert property (p_qual_low) else $error("pg loss too soon");
  // main scenarios
  c_event: cover property (lamp_strike_rst && general_reset_out_n);
  c_park: cover property ($rose(ctrl_reset_out));
  c_glitch: cover property ($fell(power_good_warning) ##1 power_good_warning);
endmodule : psr_properties
bind psr_top psr_properties #(.MIN_PULSE_CYC(MIN_PULSE_CYC), .PG_MIN_LOW(PG_MIN_LOW),
  .PG_MIN_HIGH(PG_MIN_HIGH)) psr_properties_i (.ref_clk, .rst, .power_on_sense,
  .power_good_warning, .lamp_strike_rst, .mirror_park_req, .ctrl_reset_out,
  .general_reset_out_n, .motor_reset_out_n, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// file: verif/psr_monitor_model.sv
// voltage monitor and mirror park responder facing psr_top
// assumes the bench steers its commands just after rising edges
`timescale 1ns/100ps
`default_nettype none
module psr_monitor_model
(
  // clock
  input wire logic ref_clk,
  // bench commands
  input wire logic supply_up,
  input wire logic pg_req,
  input wire logic glitch_go,
  input wire logic [1:0] glitch_len,
  input wire logic [4:0] park_dly,
  // block side
  input wire logic mirror_park_req,
  output logic power_on_sense,
  output logic power_good_warning,
  output logic mirror_park_done
);
  logic [3:0] lo_n = 4'h0; // cycles pg has been low, saturating
  logic [1:0] gl_n = 2'h0; // glitch cycles left
  logic [4:0] pk_n = 5'h0; // cycles spent parking, saturating
  initial
  begin
    power_on_sense = 1'h0;
    power_good_warning = 1'h0;
    mirror_park_done = 1'h0;
  end
  // pg always warns first; sense drops only once pg has been low 8 cycles
  always @(posedge ref_clk)
  begin
    lo_n <= power_good_warning ? 4'h0 : (lo_n == 4'hF ? lo_n : lo_n + 4'h1);
    if (supply_up) power_on_sense <= 1'h1;
    else if (lo_n >= 4'h8) power_on_sense <= 1'h0;
    power_good_warning <= pg_req && supply_up && power_on_sense && gl_n == 2'h0;
    gl_n <= glitch_go ? glitch_len : (gl_n == 2'h0 ? 2'h0 : gl_n - 2'h1);
    pk_n <= mirror_park_req ? (pk_n == 5'h1F ? pk_n : pk_n + 5'h1) : 5'h0;
    mirror_park_done <= mirror_park_req && pk_n >= park_dly;
  end
endmodule : psr_monitor_model
`default_nettype wire

// file: verif/test_power_sense_reset_outputs.sv
// self-checking bench for psr_top with shortened counts
// assumes the monitor model beside it and the bound checker
`timescale 1ns/100ps
`default_nettype none
module test_power_sense_reset_outputs;
  import psr_pkg::*;
  localparam int unsigned PULSE = 50; // short minimum low time
  localparam int unsigned QUAL = 4; // short pg qualification
  // ==========
  // signals
  logic ref_clk = 1'h0, rst = 1'h1, lamp_strike_rst = 1'h0;
  logic supply_up = 1'h0, pg_req = 1'h1, glitch_go = 1'h0;
  logic [1:0] glitch_len = 2'h0;
  logic [4:0] park_dly = 5'h0;
  logic power_on_sense, power_good_warning, mirror_park_done, mirror_park_req;
  logic ctrl_reset_out, general_reset_out_n, motor_reset_out_n, irq;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] eq_r[$]; // expected {rresp, rdata}
  logic [1:0] eq_b[$]; // expected bresp
  logic [7:0] ev_ctrl [4] = '{8'h04, 8'h0C, 8'h00, 8'h04}; // event rows
  logic ev_mtr [4] = '{1'h0, 1'h1, 1'h1, 1'h0}; // motor pin after event
  int n_errors = 0, n_checks = 0, n_cyc = 0;
  logic [31:0] rnd = 32'h6DE071A4;
  always #12.5 ref_clk = ~ref_clk;
  psr_top #(.MIN_PULSE_CYC(PULSE), .PG_MIN_LOW(QUAL), .PG_MIN_HIGH(QUAL)) psr_top_i
  (
    .ref_clk, .rst, .power_on_sense, .power_good_warning, .lamp_strike_rst,
    .mirror_park_done, .mirror_park_req, .ctrl_reset_out, .general_reset_out_n,
    .motor_reset_out_n, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  psr_monitor_model psr_monitor_model_i
  (
    .ref_clk, .supply_up, .pg_req, .glitch_go, .glitch_len, .park_dly,
    .mirror_park_req, .power_on_sense, .power_good_warning, .mirror_park_done
  );
  // ==========
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // unused upper data bytes carry random noise the block must ignore
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge ref_clk);
    rnd = xs(rnd);
    eq_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {rnd[31:8], d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge ref_clk);
    eq_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask : rd
  // release both pins and see them come up after the minimum pulse
  task automatic rel;
    wr(CMD_OFS, 8'h03, RESP_OKAY);
    cyc(PULSE + 5);
    chk("gen free", 1'h1, general_reset_out_n);
    chk("mtr free", 1'h1, motor_reset_out_n);
  endtask : rel
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // response watcher takes the oldest note on each answer; also the hang limit
  always @(posedge ref_clk)
  begin
    if (s_axi_rvalid && s_axi_rready) chk("read", eq_r.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", eq_b.pop_front(), s_axi_bresp);
    n_cyc++;
    if (n_cyc == 10000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  // ==========
  // scenarios
  initial
  begin
    cyc(4);
    rst <= 1'h0;
    supply_up <= 1'h1;
    rd(CTRL_OFS, {RESP_OKAY, 28'h0, CTRL_RESET});
    rd(INT_MASK_OFS, {RESP_OKAY, 28'h0, INT_MASK_RESET});
    rd(8'h20, {RESP_SLVERR, 32'h0});
    wr(8'h24, 8'hFF, RESP_SLVERR);
    cyc(PULSE);
    chk("gen held", 1'h0, general_reset_out_n);
    chk("mtr held", 1'h0, motor_reset_out_n);
    wr(CMD_OFS, 8'h03, RESP_OKAY);
    cyc(PULSE - 5);
    chk("gen pulse", 1'h0, general_reset_out_n);
    rel();
    // each force bit drives its own pin; the general one leaves the motor pin alone
    wr(CTRL_OFS, 8'h05, RESP_OKAY);
    cyc(3);
    chk("gen forced", 1'h0, general_reset_out_n);
    chk("mtr unforced", 1'h1, motor_reset_out_n);
    wr(CTRL_OFS, 8'h06, RESP_OKAY);
    cyc(3);
    chk("mtr forced", 1'h0, motor_reset_out_n);
    wr(CTRL_OFS, CTRL_RESET, RESP_OKAY);
    rel();
    // lamp strike with motor auto on and lamp-masked, software reset with motor auto off and on
    for (int i = 0; i < 4; i++)
    begin
      wr(CTRL_OFS, ev_ctrl[i], RESP_OKAY);
      if (i >= 2) wr(CMD_OFS, 8'h04, RESP_OKAY);
      else lamp_strike_rst <= 1'h1;
      @(posedge ref_clk);
      lamp_strike_rst <= 1'h0;
      cyc(150);
      chk("gen early", 1'h1, general_reset_out_n);
      cyc(60);
      chk("gen event", 1'h0, general_reset_out_n);
      chk("mtr event", ev_mtr[i], motor_reset_out_n);
      rel();
    end
    // short pg drops, up to one below the qualification count
    for (int n = 1; n < QUAL; n++)
    begin
      glitch_len <= n[1:0];
      glitch_go <= 1'h1;
      @(posedge ref_clk);
      glitch_go <= 1'h0;
      cyc(20);
    end
    chk("no park", 1'h0, mirror_park_req);
    chk("no hold", 1'h0, ctrl_reset_out);
    // qualified pg loss: park, controller hold, pins, interrupts
    wr(INT_STAT_OFS, 8'h0F, RESP_OKAY);
    rnd = xs(rnd);
    park_dly <= rnd[4:0];
    pg_req <= 1'h0;
    cyc(60);
    chk("parked", 1'h0, mirror_park_req);
    chk("ctrl held", 1'h1, ctrl_reset_out);
    cyc(160);
    chk("gen loss", 1'h0, general_reset_out_n);
    chk("mtr loss", 1'h0, motor_reset_out_n);
    chk("ctrl still", 1'h1, ctrl_reset_out);
    pg_req <= 1'h1;
    cyc(3);
    chk("ctrl early", 1'h1, ctrl_reset_out);
    cyc(12);
    chk("ctrl free", 1'h0, ctrl_reset_out);
    rd(INT_STAT_OFS, {RESP_OKAY, 28'h0, 4'hF});
    chk("irq masked", 1'h0, irq);
    wr(INT_MASK_OFS, 8'h01, RESP_OKAY);
    chk("irq set", 1'h1, irq);
    wr(INT_STAT_OFS, 8'h0F, RESP_OKAY);
    chk("irq clear", 1'h0, irq);
    rd(INT_STAT_OFS, {RESP_OKAY, 32'h0});
    rel();
    // supplies lost and back: pins low, then wait for software again
    supply_up <= 1'h0;
    cyc(20);
    chk("gen sense", 1'h0, general_reset_out_n);
    chk("mtr sense", 1'h0, motor_reset_out_n);
    supply_up <= 1'h1;
    cyc(20);
    chk("gen rehold", 1'h0, general_reset_out_n);
    rel();
    wrap_up();
  end
endmodule : test_power_sense_reset_outputs
`default_nettype wire
